// file: atm_cell_model.sv
// logic cell and timer side: counts rising edges of the period strobe
`default_nettype none
module atm_cell_model (
  // clock, reset and strobe
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       strobe_i,
  // edges seen, as a timer clocked by the strobe would count them
  output logic      [7:0] edges_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  // sampling on the system clock is safe since the strobe is registered
  always_ff @(posedge clk_i) begin
    prev <= strobe_i;
    if (rst_i) edges_o <= 8'h00;
    else if (strobe_i && !prev) edges_o <= edges_o + 8'h01;
  end
endmodule
`default_nettype wire

// file: atm_clk_gen.sv
// timer clock generator: source choice and prescaler as enable pulses
`default_nettype none
module atm_clk_gen
  import atm_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // oscillator level from another domain
  input  wire logic fast_osc_i,
  // configuration and tick
  atm_clk_if.gen    cif
);
  logic [2:0] osc_sync;
  logic       osc_prev;
  logic       raw_tick;
  logic [2:0] div_cnt;

  // mask of low counter bits that must all be set before the tick goes out
  function automatic logic [2:0] div_mask(input logic [1:0] ps);
    case (ps)
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction

  // three-stage synchroniser; the edge is seen only when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_sync <= 3'h0;
      osc_prev <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[1:0], fast_osc_i};
      if (osc_sync[2] == osc_sync[1]) begin
        osc_prev <= osc_sync[2];
      end
    end
  end

  // raw source: every system cycle, or each settled oscillator rising edge
  always_comb begin
    if (cif.src_sel == ATM_SRC_FASTOSC) begin
      raw_tick = osc_sync[2] & osc_sync[1] & ~osc_prev;
    end else begin
      raw_tick = 1'b1;
    end
  end

  // prescaler counts raw ticks; divide by 1, 2, 4 or 8
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 3'h0;
    end else if (raw_tick) begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  assign cif.tick = raw_tick & ((div_cnt & div_mask(cif.ps_sel)) == div_mask(cif.ps_sel));
endmodule
`default_nettype wire

// file: atm_clk_if.sv
// carrier between the register side and the timer clock generator
`default_nettype none
interface atm_clk_if;
  logic       src_sel;   // clock_source_select
  logic [1:0] ps_sel;    // prescale_select
  logic       tick;      // one-cycle prescaled timer enable

  modport ctrl (output src_sel, output ps_sel, input tick);
  modport gen (input src_sel, input ps_sel, output tick);
endinterface
`default_nettype wire

// file: atm_pkg.sv
// constants shared by the angular timer clock, selection and output logic
`default_nettype none
package atm_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] ATM_CLK_SEL_OFS  = 8'h00; // timer_clock_select_register
  localparam logic [7:0] ATM_CTRL0_OFS    = 8'h04; // timer_control_register_zero
  localparam logic [7:0] ATM_CTRL1_OFS    = 8'h08; // timer_control_register_one
  localparam logic [7:0] ATM_SIG_SEL_OFS  = 8'h0C; // input_signal_select_register
  localparam logic [7:0] ATM_MISS_HI_OFS  = 8'h10; // missing_pulse_delay_high
  localparam logic [7:0] ATM_MISS_LO_OFS  = 8'h14; // missing_pulse_delay_low
  localparam logic [7:0] ATM_ERR_HI_OFS   = 8'h18; // setpoint_error_high
  localparam logic [7:0] ATM_ERR_LO_OFS   = 8'h1C; // setpoint_error_low
  localparam logic [7:0] ATM_IRQ_STAT_OFS = 8'h20; // sticky event flags, write one to clear
  localparam logic [7:0] ATM_IRQ_MASK_OFS = 8'h24; // event enables

  // field positions
  localparam int ATM_CS_BIT    = 0; // clock_source_select
  localparam int ATM_PS_LSB    = 0; // prescale_select low bit
  localparam int ATM_PS_W      = 2;
  localparam int ATM_PHP_BIT   = 0; // phase_strobe_polarity
  localparam int ATM_PRP_BIT   = 1; // period_strobe_polarity
  localparam int ATM_MPP_BIT   = 2; // missed_strobe_polarity
  localparam int ATM_VALID_BIT = 3; // read-only valid indication
  localparam int ATM_EV_PHASE  = 0;
  localparam int ATM_EV_PERIOD = 1;
  localparam int ATM_EV_MISSED = 2;
  localparam int ATM_EV_W      = 3;

  // reset values
  localparam logic [7:0]  ATM_BYTE_RST = 8'h00;
  localparam logic [15:0] ATM_WORD_RST = 16'h0000;

  // clock source encoding
  typedef enum logic {ATM_SRC_SYSCLK, ATM_SRC_FASTOSC} atm_src_e;
endpackage
`default_nettype wire

// file: atm_timer_io.sv
// angular timer clock, input selection, output strobes and error registers
// Functional notes
// - raw timer clock is system clock or fast oscillator, by one select bit
// - prescaler divides the raw clock by one, two, four or eight
// - all timer operations advance only on the prescaled tick
// - measured input chosen from several sources by the signal select field
// - phase strobe goes to logic cells, polarity set by its bit
// - period strobe offered to general timers, measurement unit and logic cells
// - period strobe inverted or not by its polarity bit
// - missed strobe goes to logic cells, polarity set by its bit
// - missed strobe asserts when counter minus latched period reaches delay
// - delay high byte is held until the low byte is written
// - read-only error equals latched period minus set-point threshold
// - without valid, all three strobes are held off, as are their interrupts save a missed event in the first cycle
`default_nettype none
module atm_timer_io
  import atm_pkg::*;
#(
  parameter int NUM_SRC = 8,
  parameter int SEL_W   = 3
)(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  // interrupt
  output logic                    irq_o,
  // clock source and input signal pins
  input  wire logic               fast_osc_i,
  input  wire logic [NUM_SRC-1:0] sig_src_i,
  // counting core
  input  wire logic               valid_i,
  input  wire logic               phase_raw_i,
  input  wire logic               period_raw_i,
  input  wire logic [15:0]        period_count_i,
  input  wire logic [15:0]        latched_period_i,
  input  wire logic [15:0]        setpoint_threshold_i,
  output logic                    timer_tick_o,
  output logic                    measured_sig_o,
  // strobes to logic cells and timers
  output logic                    angle_phase_strobe_o,
  output logic                    period_strobe_o,
  output logic                    missed_pulse_strobe_o
);
  // the clock generator sits behind an interface so that the selects and the tick
  // travel together; the core never sees the raw oscillator
  atm_clk_if cif ();

  // software-visible configuration
  logic              clock_source_select;
  logic [1:0]        prescale_select;
  logic              phase_strobe_polarity;
  logic              period_strobe_polarity;
  logic              missed_strobe_polarity;
  logic [SEL_W-1:0]  sig_sel;
  logic [7:0]        miss_hold;
  logic [15:0]       missing_pulse_delay;
  logic [15:0]       setpoint_error;
  logic              missed_raw;
  logic [ATM_EV_W-1:0] ev_stat;
  logic [ATM_EV_W-1:0] ev_mask;
  logic [ATM_EV_W-1:0] ev_now;
  logic [ATM_EV_W-1:0] ev_prev;
  logic [ATM_EV_W-1:0] ev_pulse;
  // input synchronisers
  logic [2:0]        sync_q [NUM_SRC];
  logic [NUM_SRC-1:0] sig_clean;
  // bus decode
  logic              bus_req;
  logic              wr_en;
  logic [31:0]       next_dat;
  logic signed [16:0] miss_diff;

  // drives the clock generator from the software settings
  assign cif.src_sel = clock_source_select;
  assign cif.ps_sel  = prescale_select;

  atm_clk_gen u_clk_gen (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .fast_osc_i (fast_osc_i),
    .cif        (cif)
  );

  // the core is handed the prescaled tick as its only advance enable
  // a core that counted on the raw clock would drift from every count here
  assign timer_tick_o = cif.tick;

  // polarity: xor with its bit, strobe held low while not valid
  function automatic logic pol_out(input logic strobe, input logic vld, input logic pol);
    pol_out = (strobe & vld) ^ pol;
  endfunction

  // true when the bus address hits the given offset
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // bus request; writes land only in the low byte lane
  // every register is one byte wide, so the upper lanes are ignored
  // the request drops out once ack is high, so one request makes one access
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr_en   = bus_req & we_i & sel_i[0];

  // each source pin is synchronised; a change counts once stages two and three agree
  // costs four cycles of latency per pin, traded for freedom from metastable glitches
  generate
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync_q[g]    <= 3'h0;
          sig_clean[g] <= 1'b0;
        end else begin
          sync_q[g] <= {sync_q[g][1:0], sig_src_i[g]};
          if (sync_q[g][2] == sync_q[g][1]) begin
            sig_clean[g] <= sync_q[g][2];
          end
        end
      end
    end
  endgenerate

  // source selection; an out of range select reads as low
  // registered so that the measured input is free of multiplexer glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      measured_sig_o <= 1'b0;
    end else if (32'(sig_sel) < NUM_SRC) begin
      measured_sig_o <= sig_clean[sig_sel];
    end else begin
      measured_sig_o <= 1'b0;
    end
  end

  // clock and control bits
  // unused upper data bits are dropped; reads return zero there
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_source_select    <= 1'b0;
      prescale_select        <= 2'h0;
      phase_strobe_polarity  <= 1'b0;
      period_strobe_polarity <= 1'b0;
      missed_strobe_polarity <= 1'b0;
      sig_sel                <= '0;
    end else if (wr_en) begin
      if (hit(adr_i, ATM_CLK_SEL_OFS)) begin
        clock_source_select <= dat_i[ATM_CS_BIT];
      end
      if (hit(adr_i, ATM_CTRL0_OFS)) begin
        prescale_select <= dat_i[ATM_PS_LSB +: ATM_PS_W];
      end
      if (hit(adr_i, ATM_CTRL1_OFS)) begin
        phase_strobe_polarity  <= dat_i[ATM_PHP_BIT];
        period_strobe_polarity <= dat_i[ATM_PRP_BIT];
        missed_strobe_polarity <= dat_i[ATM_MPP_BIT];
      end
      if (hit(adr_i, ATM_SIG_SEL_OFS)) begin
        sig_sel <= dat_i[SEL_W-1:0];
      end
    end
  end

  // delay pair: high byte waits in a holding register so the pair changes at once
  // software must write the high byte first; a lone low write reuses the old held byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miss_hold           <= ATM_BYTE_RST;
      missing_pulse_delay <= ATM_WORD_RST;
    end else if (wr_en) begin
      if (hit(adr_i, ATM_MISS_HI_OFS)) begin
        miss_hold <= dat_i[7:0];
      end
      if (hit(adr_i, ATM_MISS_LO_OFS)) begin
        missing_pulse_delay <= {miss_hold, dat_i[7:0]};
      end
    end
  end

  // signed distance of the running count past the latched period
  assign miss_diff = $signed({1'b0, period_count_i}) - $signed({1'b0, latched_period_i});

  // missed level updates on the prescaled tick and clears at once while not valid, so it follows the count
  // the delay is two's complement, so a negative delay fires before the latched period
  // the compare is sampled once per tick, so a slow prescale delays the output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      missed_raw <= 1'b0;
    end else if (!valid_i) begin
      missed_raw <= 1'b0;
    end else if (cif.tick) begin
      missed_raw <= (miss_diff >= 17'(signed'(missing_pulse_delay)));
    end
  end

  // error value is refreshed every cycle; reading the two halves at different
  // times can tear if the latched period changes in between
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setpoint_error <= ATM_WORD_RST;
    end else begin
      setpoint_error <= latched_period_i - setpoint_threshold_i;
    end
  end

  // output strobes with polarity, registered
  // registering costs one cycle but keeps the logic cells free of decode glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      angle_phase_strobe_o  <= 1'b0;
      period_strobe_o       <= 1'b0;
      missed_pulse_strobe_o <= 1'b0;
    end else begin
      angle_phase_strobe_o  <= pol_out(phase_raw_i, valid_i, phase_strobe_polarity);
      period_strobe_o       <= pol_out(period_raw_i, valid_i, period_strobe_polarity);
      missed_pulse_strobe_o <= pol_out(missed_raw, valid_i, missed_strobe_polarity);
    end
  end

  // events are rising edges of the internal strobes, before polarity
  // gating phase and period with valid here keeps a suppressed strobe from setting its flag
  assign ev_now[ATM_EV_PHASE]  = phase_raw_i & valid_i;
  assign ev_now[ATM_EV_PERIOD] = period_raw_i & valid_i;
  assign ev_now[ATM_EV_MISSED] = missed_raw;
  assign ev_pulse              = ev_now & ~ev_prev;

  // previous internal levels for edge detection; reset to the idle low level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_prev <= '0;
    end else begin
      ev_prev <= ev_now;
    end
  end

  // sticky status; a new event in the clearing cycle keeps its bit set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_stat <= '0;
    end else if (wr_en && hit(adr_i, ATM_IRQ_STAT_OFS)) begin
      ev_stat <= (ev_stat & ~dat_i[ATM_EV_W-1:0]) | ev_pulse;
    end else begin
      ev_stat <= ev_stat | ev_pulse;
    end
  end

  // interrupt mask
  // a masked flag still records its event and can be polled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_mask <= '0;
    end else if (wr_en && hit(adr_i, ATM_IRQ_MASK_OFS)) begin
      ev_mask <= dat_i[ATM_EV_W-1:0];
    end
  end

  // level interrupt, high while any enabled flag is set
  assign irq_o = |(ev_stat & ev_mask);

  // read multiplexer; unmapped offsets read zero and still acknowledge
  // decoded on word address bits only, so byte offsets alias within a word
  always_comb begin
    next_dat = 32'h0000_0000;
    case (adr_i[7:2])
      ATM_CLK_SEL_OFS[7:2]: next_dat[ATM_CS_BIT] = clock_source_select;
      ATM_CTRL0_OFS[7:2]:   next_dat[ATM_PS_LSB +: ATM_PS_W] = prescale_select;
      ATM_CTRL1_OFS[7:2]: begin
        next_dat[ATM_PHP_BIT]   = phase_strobe_polarity;
        next_dat[ATM_PRP_BIT]   = period_strobe_polarity;
        next_dat[ATM_MPP_BIT]   = missed_strobe_polarity;
        next_dat[ATM_VALID_BIT] = valid_i;
      end
      ATM_SIG_SEL_OFS[7:2]:  next_dat[SEL_W-1:0] = sig_sel;
      ATM_MISS_HI_OFS[7:2]:  next_dat[7:0] = miss_hold;
      ATM_MISS_LO_OFS[7:2]:  next_dat[7:0] = missing_pulse_delay[7:0];
      ATM_ERR_HI_OFS[7:2]:   next_dat[7:0] = setpoint_error[15:8];
      ATM_ERR_LO_OFS[7:2]:   next_dat[7:0] = setpoint_error[7:0];
      ATM_IRQ_STAT_OFS[7:2]: next_dat[ATM_EV_W-1:0] = ev_stat;
      ATM_IRQ_MASK_OFS[7:2]: next_dat[ATM_EV_W-1:0] = ev_mask;
      default:               next_dat = 32'h0000_0000;
    endcase
  end

  // one wait state: ack and read data one edge after the request is seen
  // a fixed latency keeps the master simple; ack never stretches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        dat_o <= next_dat;
      end
    end
  end
endmodule
`default_nettype wire

// file: atm_timer_io_sva.sv
// checker for the angular timer io block, watching only its ports
`default_nettype none
module atm_timer_io_sva
  import atm_pkg::*;
#(
  parameter int NUM_SRC = 8
)(
  // clock, reset and bus
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  input  wire logic               ack_o,
  input  wire logic               irq_o,
  // pins and strobes
  input  wire logic [NUM_SRC-1:0] sig_src_i,
  input  wire logic               valid_i,
  input  wire logic               phase_raw_i,
  input  wire logic               period_raw_i,
  input  wire logic               timer_tick_o,
  input  wire logic               measured_sig_o,
  input  wire logic               angle_phase_strobe_o,
  input  wire logic               period_strobe_o,
  input  wire logic               missed_pulse_strobe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pol;
  logic [2:0] mask;
  logic [2:0] ssel;
  logic [1:0] ps;
  logic       src;
  logic [3:0] gap;
  logic [3:0] age;
  logic       wr;
  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  // shadow of the select, control and mask fields, taken at the same edge as the slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {pol, mask, ssel, ps, src} <= '0;
    end else if (wr) begin
      if (adr_i == ATM_CLK_SEL_OFS) src <= dat_i[ATM_CS_BIT];
      if (adr_i == ATM_CTRL0_OFS) ps <= dat_i[1:0];
      if (adr_i == ATM_CTRL1_OFS) pol <= dat_i[2:0];
      if (adr_i == ATM_SIG_SEL_OFS) ssel <= dat_i[2:0];
      if (adr_i == ATM_IRQ_MASK_OFS) mask <= dat_i[2:0];
    end
  end
  // age since a clock change, so a partial first tick period is skipped
  always_ff @(posedge clk_i) begin
    if (rst_i || (wr && adr_i inside {ATM_CLK_SEL_OFS, ATM_CTRL0_OFS})) age <= '0;
    else if (age != 4'hf) age <= age + 4'h1;
    if (rst_i || timer_tick_o) gap <= '0;
    else if (gap != 4'hf) gap <= gap + 4'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered after one cycle");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("acknowledge held longer than one cycle");
  AST_PHASE: assert property (!$past(rst_i) |->
    angle_phase_strobe_o == ($past(phase_raw_i && valid_i) ^ $past(pol[0])))
    else $error("phase strobe level wrong");
  AST_PERIOD: assert property (!$past(rst_i) |->
    period_strobe_o == ($past(period_raw_i && valid_i) ^ $past(pol[1])))
    else $error("period strobe level wrong");
  AST_MISS_OFF: assert property ((!valid_i && $stable(pol)) [*3] |->
    missed_pulse_strobe_o == pol[2]) else $error("missed strobe not held off");
  AST_IRQ_MASK: assert property (mask == 3'h0 |-> !irq_o)
    else $error("interrupt high with every event masked");
  AST_TICK_DIV: assert property (timer_tick_o && !src && age > 4'hc |->
    gap == (4'h1 << ps) - 4'h1) else $error("tick spacing wrong");
  AST_MEAS: assert property (($stable(sig_src_i) && $stable(ssel)) [*7] |->
    measured_sig_o == (ssel < NUM_SRC ? sig_src_i[ssel] : 1'b0))
    else $error("measured signal not the selected pin");
  cover property (timer_tick_o && ps == 2'h3);
  cover property (irq_o);
  cover property (missed_pulse_strobe_o && valid_i && !pol[2]);
endmodule
`default_nettype wire

// file: test_atm_timer_io.sv
// self-checking bench for the angular timer io block
`default_nettype none
module test_atm_timer_io;
  import atm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NSRC = 6;
  logic            clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic            osc = 1'b0, valid = 1'b0, ph_raw = 1'b0, pr_raw = 1'b0;
  logic [7:0]      adr = 8'h00;
  logic [3:0]      sel = 4'h0;
  logic [31:0]     wdat = 32'h0000_0000;
  logic [NSRC-1:0] sig = '0;
  logic [15:0]     cnt = 16'h0000, lat = 16'h0001, thr = 16'h0000, err;
  logic [31:0]     rdat, exp_v;
  logic            tick, meas, ph_o, pr_o, ms_o, ack, irq;
  logic [7:0]      edges;
  logic [31:0]     q[$];
  int              bad_count = 0, compares = 0, cycles = 0, n;
  integer          seed = 32'ha45cebc5;
  always #4 clk_i = ~clk_i;
  // fast oscillator free-running, phase unrelated to the system clock
  always #31.25 osc = ~osc;
  atm_timer_io #(.NUM_SRC(NSRC), .SEL_W(3)) atm_timer_io_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .irq_o(irq), .fast_osc_i(osc), .sig_src_i(sig),
    .valid_i(valid), .phase_raw_i(ph_raw), .period_raw_i(pr_raw), .period_count_i(cnt),
    .latched_period_i(lat), .setpoint_threshold_i(thr), .timer_tick_o(tick),
    .measured_sig_o(meas), .angle_phase_strobe_o(ph_o), .period_strobe_o(pr_o),
    .missed_pulse_strobe_o(ms_o));
  atm_cell_model atm_cell_model_i (.clk_i(clk_i), .rst_i(rst_i), .strobe_i(pr_o),
    .edges_o(edges));
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic results();
    $display("compares=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one classic cycle, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic mchk(input logic [15:0] c, input logic e);
    cnt <= c;
    repeat (6) @(posedge clk_i);
    cmp({31'h0, ms_o}, {31'h0, e});
  endtask
  // read answers are matched against the oldest expected value
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      exp_v = q.pop_front();
      cmp(rdat & 32'h0000_00ff, exp_v);
    end
  end
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    thr <= 16'($random(seed));
    lat <= 16'($random(seed));
    bus(1'b1, ATM_ERR_HI_OFS, 32'h0000_00ff);
    err = lat - thr;
    for (int a = 0; a <= 'h30; a += 4) begin
      rd(8'(a), a == 'h18 ? {24'h0, err[15:8]} : a == 'h1c ? {24'h0, err[7:0]} : '0);
    end
    lat <= 16'h0001;
    $display("test registers done");
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, ATM_CTRL0_OFS, 32'(p));
      repeat (16) @(posedge clk_i);
      n = 0;
      repeat (64) @(posedge clk_i) n += int'(tick === 1'b1);
      cmp(32'(n), 32'(64 >> p));
    end
    bus(1'b1, ATM_CTRL0_OFS, 32'h0000_0000);
    bus(1'b1, ATM_CLK_SEL_OFS, 32'h0000_0001);
    repeat (16) @(posedge clk_i);
    n = 0;
    repeat (250) @(posedge clk_i) n += int'(tick === 1'b1);
    cmp(32'(n >= 31 && n <= 33), 32'h0000_0001);
    bus(1'b1, ATM_CLK_SEL_OFS, 32'h0000_0000);
    $display("test clock done");
    valid <= 1'b1;
    for (int p = 0; p < 8; p++) begin
      bus(1'b1, ATM_CTRL1_OFS, 32'(p));
      repeat (19) @(posedge clk_i) {ph_raw, pr_raw} <= 2'($random(seed));
      @(posedge clk_i) {ph_raw, pr_raw} <= 2'b00;
      repeat (3) @(posedge clk_i);
      cmp({29'h0, ph_o, pr_o, ms_o}, {29'h0, p[0], p[1], p[2]});
      {valid, ph_raw, pr_raw} <= 3'b011;
      repeat (3) @(posedge clk_i);
      cmp({29'h0, ph_o, pr_o, ms_o}, {29'h0, p[0], p[1], p[2]});
      {valid, ph_raw, pr_raw} <= 3'b100;
    end
    n = int'(edges);
    repeat (4) begin
      @(posedge clk_i) pr_raw <= 1'b1;
      @(posedge clk_i) pr_raw <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
    cmp(32'(8'(edges - 8'(n))), 32'h0000_0004);
    $display("test strobes done");
    valid <= 1'b0;
    bus(1'b1, ATM_IRQ_STAT_OFS, 32'h0000_0007);
    @(posedge clk_i) {ph_raw, pr_raw} <= 2'b11;
    @(posedge clk_i) {ph_raw, pr_raw} <= 2'b00;
    rd(ATM_IRQ_STAT_OFS, 32'h0000_0000);
    valid <= 1'b1;
    @(posedge clk_i) ph_raw <= 1'b1;
    @(posedge clk_i) ph_raw <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp({31'h0, irq}, 32'h0000_0000);
    rd(ATM_IRQ_STAT_OFS, 32'h0000_0001);
    bus(1'b1, ATM_IRQ_MASK_OFS, 32'h0000_0001);
    cmp({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, ATM_IRQ_STAT_OFS, 32'h0000_0001);
    cmp({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, ATM_IRQ_MASK_OFS, 32'h0000_0000);
    $display("test interrupt done");
    bus(1'b1, ATM_CTRL1_OFS, 32'h0000_0000);
    lat <= 16'h0064;
    bus(1'b1, ATM_MISS_HI_OFS, 32'h0000_0000);
    bus(1'b1, ATM_MISS_LO_OFS, 32'h0000_0005);
    mchk(16'h0068, 1'b0);
    mchk(16'h0069, 1'b1);
    bus(1'b1, ATM_MISS_HI_OFS, 32'h0000_0080);
    mchk(16'h0068, 1'b0);
    rd(ATM_MISS_HI_OFS, 32'h0000_0080);
    bus(1'b1, ATM_MISS_LO_OFS, 32'h0000_0010);
    mchk(16'h0068, 1'b1);
    valid <= 1'b0;
    mchk(16'h0068, 1'b0);
    $display("test missed pulse done");
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, ATM_SIG_SEL_OFS, 32'(s));
      sig <= NSRC'($random(seed));
      repeat (8) @(posedge clk_i);
      cmp({31'h0, meas}, {31'h0, s < NSRC ? sig[s] : 1'b0});
    end
    $display("test input select done");
    results();
  end
endmodule
bind atm_timer_io atm_timer_io_sva #(.NUM_SRC(NUM_SRC)) atm_timer_io_sva_i (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .ack_o(ack_o), .irq_o(irq_o), .sig_src_i(sig_src_i), .valid_i(valid_i),
  .phase_raw_i(phase_raw_i), .period_raw_i(period_raw_i), .timer_tick_o(timer_tick_o),
  .measured_sig_o(measured_sig_o), .angle_phase_strobe_o(angle_phase_strobe_o),
  .period_strobe_o(period_strobe_o), .missed_pulse_strobe_o(missed_pulse_strobe_o));
`default_nettype wire
